// ===== itcb_config_bank.v
// Serial target and threshold register bank with fuse-backed power-up defaults
`timescale 1ns/10ps
`default_nettype none
`include "itcb_map.vh"

// Summary of operation
// RULE1: All thresholds read and written over two-wire target
// RULE2: Bits taken on clock rise, MSB first
// RULE3: Answer only when address bit matches select pin
// RULE4: One address per register for read and write
// RULE5: Unprogrammed thresholds power up as zero
// RULE6: Blown fuse values become the power-up defaults
// RULE7: Set lock bit blocks any further fuse burning
// RULE8: Bus writes override fuses until next power cycle
// RULE9: Registers 1 to 4 hold 4-bit codes
// RULE10: Registers 5 and 6 hold 3-bit codes
// RULE11: Lock register at 0x15, burnt with fuses
// RULE12: Reserved bits read zero, writes ignored
// RULE13: Write: address, pointer, data; read after pointer
module itcb_config_bank #(
  parameter BURN_CYCLES = `ITCB_BURN_TIME_MS * `ITCB_CLK_KHZ
) (
  // Clock and resets
  input wire core_clk,
  input wire sys_rst,
  input wire otpBlank,
  // Serial bus, open drain data
  input wire sclIn,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  // Address strap
  input wire addressSelectPin,
  // Threshold codes toward the comparators
  output wire [3:0] overvoltageLevel,
  output wire [3:0] undervoltageLevel,
  output wire [3:0] turnOnLevel,
  output wire [3:0] turnOffLevel,
  output wire [2:0] logicRailResetLevel,
  output wire [2:0] coreRailResetLevel,
  // Fuse status
  output wire fuseLocked,
  output wire fuseBurnBusy
);

  // One-hot serial states
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_ADDR_ACK = 9'h004;
  localparam [8:0] ST_PTR = 9'h008;
  localparam [8:0] ST_PTR_ACK = 9'h010;
  localparam [8:0] ST_WDATA = 9'h020;
  localparam [8:0] ST_WDATA_ACK = 9'h040;
  localparam [8:0] ST_RDATA = 9'h080;
  localparam [8:0] ST_RDATA_ACK = 9'h100;

  // Pin events from the sampler
  wire sdaLevel;
  wire addrSel;
  wire sclRise;
  wire sclFall;
  wire startSeen;
  wire stopSeen;

  // Fuse side
  wire [47:0] fuseData;
  wire fuseLock;
  wire burnBusy;
  wire [47:0] burnImage;

  // Serial engine state
  reg [8:0] state; // Current serial state
  reg rdNext; // Read continues after master acknowledge
  reg [2:0] bitCnt; // Bit position in the byte
  reg [7:0] shiftReg; // Incoming or outgoing byte
  reg [7:0] ptr; // Register pointer
  reg readMode; // Direction bit of the address byte
  reg ackPhase; // Low while waiting to drive acknowledge
  reg regWrite; // One-cycle write strobe to the bank
  reg [7:0] wrByte; // Byte to be written

  // Register storage
  reg [7:0] cfgReg [1:`ITCB_REG_COUNT]; // Threshold codes
  reg loadPending; // Fuse copy still to be done
  reg lockRequest; // Lock staged for the next burn
  reg burnStart; // One-cycle burn request
  integer i;

  wire [7:0] inByte = {shiftReg[6:0], sdaLevel}; // see RULE2
  wire [7:0] readByte;

  // Pointer lies inside the threshold block
  function isCfg;
    input [7:0] p;
    begin
      isCfg = (p >= `ITCB_REG_OV) && (p <= `ITCB_REG_CORE);
    end
  endfunction

  // Implemented bits of a threshold register
  function [7:0] fieldMask;
    input [7:0] p;
    begin
      if (p <= `ITCB_REG_TURN_OFF_LEVEL) begin
        fieldMask = `ITCB_MASK4; // see RULE9
      end else begin
        fieldMask = `ITCB_MASK3; // see RULE10
      end
    end
  endfunction

  itcb_line_sampler uSampler (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .addrSelIn(addressSelectPin),
    .sdaLevel(sdaLevel),
    .addrSel(addrSel),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  itcb_fuse_store #(
    .BURN_CYCLES(BURN_CYCLES)
  ) uFuses (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .otpBlank(otpBlank),
    .burnStart(burnStart),
    .burnImage(burnImage),
    .burnLock(lockRequest),
    .fuseData(fuseData),
    .fuseLock(fuseLock),
    .burnBusy(burnBusy)
  );

  // Current register contents are what gets burnt
  assign burnImage = {cfgReg[6], cfgReg[5], cfgReg[4], cfgReg[3], cfgReg[2], cfgReg[1]};

  // Read mux; same pointer serves reads and writes, unmapped reads zero
  assign readByte = isCfg(ptr) ? (cfgReg[ptr[2:0]] & fieldMask(ptr)) : // see RULE4
    (ptr == `ITCB_REG_LOCK) ? {7'h00, fuseLock | lockRequest} :
    (ptr == `ITCB_REG_BURN) ? {6'h00, fuseLock, burnBusy} :
    8'h00; // see RULE12

  // Serial target engine; it never drives the clock, only pulls data low
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      rdNext <= 1'b0;
      bitCnt <= 3'h0;
      shiftReg <= 8'h00;
      ptr <= 8'h00;
      readMode <= 1'b0;
      ackPhase <= 1'b0;
      sdaOe <= 1'b0;
      sdaOut <= 1'b0;
      regWrite <= 1'b0;
      wrByte <= 8'h00;
    end else begin
      regWrite <= 1'b0;
      sdaOut <= 1'b0; // Open drain: only the enable moves
      if (stopSeen) begin
        // Stop frees the line in any state
        state <= ST_IDLE;
        rdNext <= 1'b0;
        sdaOe <= 1'b0;
      end else if (startSeen) begin
        // Start or repeated start begins a new address byte
        state <= ST_ADDR;
        rdNext <= 1'b0;
        bitCnt <= 3'h0;
        sdaOe <= 1'b0;
      end else if (rdNext) begin
        // Master acknowledged: put the next copy of the byte out
        if (sclFall) begin
          rdNext <= 1'b0;
          shiftReg <= readByte;
          sdaOe <= ~readByte[7];
          bitCnt <= 3'h0;
          state <= ST_RDATA;
        end
      end else begin
        case (state)
          ST_ADDR, ST_PTR, ST_WDATA: begin
            // Shift in on clock rise, most significant bit first
            if (sclRise) begin
              shiftReg <= inByte; // see RULE2
              bitCnt <= bitCnt + 3'h1;
              ackPhase <= 1'b0;
              if (bitCnt == `ITCB_BIT_LAST) begin
                if (state == ST_ADDR) begin
                  // Foreign address: stay silent until the next start
                  if (inByte[7:2] == `ITCB_ADDR_UPPER && inByte[1] == addrSel) begin // see RULE3
                    readMode <= inByte[0];
                    state <= ST_ADDR_ACK;
                  end else begin
                    state <= ST_IDLE;
                  end
                end else if (state == ST_PTR) begin
                  ptr <= inByte; // see RULE13
                  state <= ST_PTR_ACK;
                end else begin
                  wrByte <= inByte;
                  regWrite <= 1'b1; // see RULE1
                  state <= ST_WDATA_ACK;
                end
              end
            end
          end
          ST_ADDR_ACK, ST_PTR_ACK, ST_WDATA_ACK: begin
            // First fall pulls data low, second fall releases it
            if (sclFall) begin
              if (!ackPhase) begin
                ackPhase <= 1'b1;
                sdaOe <= 1'b1;
              end else begin
                ackPhase <= 1'b0;
                sdaOe <= 1'b0;
                bitCnt <= 3'h0;
                if (state == ST_ADDR_ACK && readMode) begin
                  // Read returns the register at the pointer
                  shiftReg <= readByte; // see RULE13
                  sdaOe <= ~readByte[7];
                  state <= ST_RDATA;
                end else if (state == ST_ADDR_ACK) begin
                  state <= ST_PTR;
                end else begin
                  // Extra data bytes rewrite the same register
                  state <= ST_WDATA;
                end
              end
            end
          end
          ST_RDATA: begin
            // Next bit goes out on each fall, the master takes it on the rise
            if (sclRise) begin
              bitCnt <= bitCnt + 3'h1;
              if (bitCnt == `ITCB_BIT_LAST) begin
                state <= ST_RDATA_ACK;
              end
            end else if (sclFall) begin
              sdaOe <= ~shiftReg[6];
              shiftReg <= {shiftReg[6:0], 1'b0};
            end
          end
          ST_RDATA_ACK: begin
            // Release for the master's answer; a not-acknowledge ends the read
            if (sclFall) begin
              sdaOe <= 1'b0;
            end else if (sclRise) begin
              if (!sdaLevel) begin
                rdNext <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_IDLE: begin
            sdaOe <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register bank: factory zero at reset, fuse copy once after release, then bus writes
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 1; i <= `ITCB_REG_COUNT; i = i + 1) begin
        cfgReg[i] <= `ITCB_FACTORY; // see RULE5
      end
      loadPending <= 1'b1;
      lockRequest <= 1'b0;
      burnStart <= 1'b0;
    end else begin
      burnStart <= 1'b0;
      if (loadPending) begin
        // Blank fuses are zero, so an unprogrammed part keeps the factory code
        loadPending <= 1'b0;
        for (i = 0; i < `ITCB_REG_COUNT; i = i + 1) begin
          cfgReg[i + 1] <= fuseData[i * `ITCB_BYTE +: `ITCB_BYTE]; // see RULE6
        end
      end else if (regWrite) begin
        if (isCfg(ptr)) begin
          // Override lasts until the next power cycle reloads the fuses
          cfgReg[ptr[2:0]] <= wrByte & fieldMask(ptr); // see RULE8
        end else if (ptr == `ITCB_REG_LOCK) begin
          lockRequest <= wrByte[`ITCB_LOCK_BIT]; // see RULE11
        end else if (ptr == `ITCB_REG_BURN) begin
          // Fuse store itself refuses while locked or busy
          burnStart <= wrByte[`ITCB_BURN_GO_BIT]; // see RULE7
        end
      end
    end
  end

  // Threshold outputs come straight from the bank flops
  assign overvoltageLevel = cfgReg[1][3:0];
  assign undervoltageLevel = cfgReg[2][3:0];
  assign turnOnLevel = cfgReg[3][3:0];
  assign turnOffLevel = cfgReg[4][3:0];
  assign logicRailResetLevel = cfgReg[5][2:0];
  assign coreRailResetLevel = cfgReg[6][2:0];
  assign fuseLocked = fuseLock;
  assign fuseBurnBusy = burnBusy;

endmodule
`default_nettype wire

// ===== itcb_map.vh
// Register offsets, field masks and timing constants of the threshold configuration bank
`ifndef ITCB_MAP_VH
`define ITCB_MAP_VH

// Upper six bits of the 7-bit target address; the lowest bit follows the select pin
`define ITCB_ADDR_UPPER 6'h17

// Register pointer values
`define ITCB_REG_OV 8'h01
`define ITCB_REG_UV 8'h02
`define ITCB_REG_TON 8'h03
`define ITCB_REG_TURN_OFF_LEVEL 8'h04
`define ITCB_REG_LOGIC 8'h05
`define ITCB_REG_CORE 8'h06
`define ITCB_REG_BURN 8'h10
`define ITCB_REG_LOCK 8'h15

// Implemented bits of each register
`define ITCB_MASK4 8'h0F
`define ITCB_MASK3 8'h07
`define ITCB_MASK1 8'h01

// Factory default of every threshold register
`define ITCB_FACTORY 8'h00

// Bit positions in the burn control and lock registers
`define ITCB_BURN_GO_BIT 0
`define ITCB_BUSY_BIT 0
`define ITCB_LOCKED_BIT 1
`define ITCB_LOCK_BIT 0

// Serial bit counter value of the eighth bit
`define ITCB_BIT_LAST 3'h7

// Number of threshold registers and byte width
`define ITCB_REG_COUNT 6
`define ITCB_BYTE 8

// Fuse burn duration in milliseconds and core clock in kilohertz
`define ITCB_BURN_TIME_MS 10
`define ITCB_CLK_KHZ 40000

`endif

// ===== itcb_line_sampler.v
// Synchroniser and edge finder for the serial clock, serial data and address-select pins
`timescale 1ns/10ps
`default_nettype none

module itcb_line_sampler (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Raw pins
  input wire sclIn,
  input wire sdaIn,
  input wire addrSelIn,
  // Synchronised levels
  output wire sdaLevel,
  output wire addrSel,
  // One-cycle events
  output wire sclRise,
  output wire sclFall,
  output wire startSeen,
  output wire stopSeen
);

  reg [2:0] sclPipe; // Bit 0 is the metastable stage
  reg [2:0] sdaPipe; // Bit 0 is the metastable stage
  reg [1:0] selPipe; // Static strap, two stages only

  // Two stages for synchronising, a third one for edge detection
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclPipe <= 3'h7;
      sdaPipe <= 3'h7;
      selPipe <= 2'h0;
    end else begin
      sclPipe <= {sclPipe[1:0], sclIn};
      sdaPipe <= {sdaPipe[1:0], sdaIn};
      selPipe <= {selPipe[0], addrSelIn};
    end
  end

  // Edges look only at bits 1 and 2, never at the first stage
  assign sdaLevel = sdaPipe[1];
  assign addrSel = selPipe[1];
  assign sclRise = sclPipe[1] & ~sclPipe[2];
  assign sclFall = ~sclPipe[1] & sclPipe[2];
  // Data moving while the clock stays high marks start and stop
  assign startSeen = sclPipe[1] & sclPipe[2] & ~sdaPipe[1] & sdaPipe[2];
  assign stopSeen = sclPipe[1] & sclPipe[2] & sdaPipe[1] & ~sdaPipe[2];

endmodule
`default_nettype wire

// ===== itcb_fuse_store.v
// One-time fuse array holding power-up defaults and the programming lock
`timescale 1ns/10ps
`default_nettype none
`include "itcb_map.vh"

module itcb_fuse_store #(
  parameter BURN_CYCLES = `ITCB_BURN_TIME_MS * `ITCB_CLK_KHZ,
  parameter CNT_W = 20
) (
  // Clock and resets
  input wire core_clk,
  input wire sys_rst,
  input wire otpBlank,
  // Burn request
  input wire burnStart,
  input wire [47:0] burnImage,
  input wire burnLock,
  // Fuse contents and status
  output reg [47:0] fuseData,
  output reg fuseLock,
  output reg burnBusy
);

  reg [CNT_W-1:0] burnCnt; // Remaining burn cycles
  reg [47:0] stagedImage; // Values being burnt
  reg stagedLock; // Lock being burnt

  // Fuse cells survive a power cycle; only a blank die clears them
  always @(posedge core_clk or posedge otpBlank) begin
    if (otpBlank) begin
      fuseData <= 48'h0000_0000_0000;
      fuseLock <= 1'b0;
    end else if (burnBusy && burnCnt == {CNT_W{1'b0}}) begin
      // A blown fuse never heals, so new bits only add
      fuseData <= fuseData | stagedImage; // see RULE6
      fuseLock <= fuseLock | stagedLock; // see RULE11
    end
  end

  // Burn sequencer; a locked array ignores every request
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      burnBusy <= 1'b0;
      burnCnt <= {CNT_W{1'b0}};
      stagedImage <= 48'h0000_0000_0000;
      stagedLock <= 1'b0;
    end else if (burnBusy) begin
      if (burnCnt == {CNT_W{1'b0}}) begin
        burnBusy <= 1'b0;
      end else begin
        burnCnt <= burnCnt - 1'b1;
      end
    end else if (burnStart && !fuseLock) begin // see RULE7
      burnBusy <= 1'b1;
      burnCnt <= BURN_CYCLES[CNT_W-1:0] - 1'b1;
      stagedImage <= burnImage;
      stagedLock <= burnLock;
    end
  end

endmodule
`default_nettype wire

// ===== itcb_config_bank_assertions.sv
// Concurrent checks on the port behaviour of the threshold configuration bank
`timescale 1ns/10ps
`default_nettype none
module itcb_checker #(
  parameter BURN_CYCLES = 20
) (
  // Clock and resets
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic otpBlank,
  // Serial pins
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic addressSelectPin,
  // Threshold levels
  input wire logic [3:0] overvoltageLevel,
  input wire logic [3:0] undervoltageLevel,
  input wire logic [3:0] turnOnLevel,
  input wire logic [3:0] turnOffLevel,
  input wire logic [2:0] logicRailResetLevel,
  input wire logic [2:0] coreRailResetLevel,
  // Fuse status
  input wire logic fuseLocked,
  input wire logic fuseBurnBusy
);
  default clocking cb @(posedge core_clk); endclocking
  // Blank-die pulse also counts as reset for the fuse checks
  default disable iff (sys_rst || otpBlank);
  // Cycles since the clock pin last moved, saturating so idle stays idle
  logic [3:0] quiet;
  logic sclPrev;
  // Length of the running burn
  logic [19:0] busyCnt;
  wire [21:0] levels = {overvoltageLevel, undervoltageLevel, turnOnLevel, turnOffLevel,
    logicRailResetLevel, coreRailResetLevel};
  // Helper counters
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      quiet <= 4'h0;
      sclPrev <= 1'b1;
      busyCnt <= 20'h0_0000;
    end else begin
      sclPrev <= sclIn;
      quiet <= (sclIn != sclPrev) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
      busyCnt <= fuseBurnBusy ? busyCnt + 20'h0_0001 : 20'h0_0000;
    end
  end
  sda_open_drain_a: assert property (sdaOut == 1'b0)
    else $error("data output driven high");
  sda_hold_a: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data pull moved while clock high");
  ack_edge_a: assert property ($rose(sdaOe) |-> quiet <= 4'h4)
    else $error("data pull started away from a clock fall");
  ack_hold_a: assert property ($rose(sdaOe) |-> sdaOe [*6])
    else $error("data pull shorter than a bit time");
  level_quiet_a: assert property (!$stable(levels) |-> quiet < 4'h8)
    else $error("level changed on an idle bus");
  burn_start_a: assert property ($rose(fuseBurnBusy) |-> quiet < 4'h8)
    else $error("burn began on an idle bus");
  lock_refuse_a: assert property ($rose(fuseBurnBusy) |-> !$past(fuseLocked))
    else $error("burn began while locked");
  burn_len_a: assert property ($fell(fuseBurnBusy) |->
    busyCnt >= BURN_CYCLES - 1 && busyCnt <= BURN_CYCLES + 1)
    else $error("burn length wrong");
  lock_keep_a: assert property (fuseLocked |=> fuseLocked)
    else $error("lock fuse cleared");
  burn_c: cover property ($rose(fuseBurnBusy));
  ack_c: cover property ($rose(sdaOe));
  lock_c: cover property ($rose(fuseLocked));
endmodule
`default_nettype wire

// ===== itcb_host_model.sv
// Serial bus master model with open-drain data and a 200 ns bus clock
`timescale 1ns/10ps
`default_nettype none
module itcb_host_model (
  // Clock
  input wire logic core_clk,
  // Bus lines
  input wire logic sdaIn,
  output var logic sclOut,
  output var logic sdaPull
);
  // Idle bus: both lines released, clock stands still high
  initial begin
    sclOut = 1'b1;
    sdaPull = 1'b0;
  end
  // Wait core clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One bit; data moves a cycle after the fall to keep hold time
  task automatic bitx(input logic b, output logic r);
    tick(1);
    sdaPull <= !b;
    tick(3);
    sclOut <= 1'b1;
    tick(3);
    @(negedge core_clk) r = sdaIn;
    @(posedge core_clk) sclOut <= 1'b0;
  endtask
  // Byte MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, a);
    ack = !a;
  endtask
  // Start or repeated start
  task automatic start();
    tick(1);
    sdaPull <= 1'b0;
    tick(3);
    sclOut <= 1'b1;
    tick(4);
    sdaPull <= 1'b1;
    tick(4);
    sclOut <= 1'b0;
  endtask
  // Stop, leaving both lines released
  task automatic stop();
    tick(1);
    sdaPull <= 1'b1;
    tick(3);
    sclOut <= 1'b1;
    tick(4);
    sdaPull <= 1'b0;
    tick(4);
  endtask
  // Address, pointer, one data byte
  task automatic writeReg(input logic [6:0] dev, input logic [7:0] ptr,
    input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xfer({dev, 1'b0}, q, a0);
    xfer(ptr, q, a1);
    xfer(d, q, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // Pointer write, repeated start, one byte read closed by a refusal
  task automatic readReg(input logic [6:0] dev, input logic [7:0] ptr,
    output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, n;
    start();
    xfer({dev, 1'b0}, q, a0);
    xfer(ptr, q, a1);
    start();
    xfer({dev, 1'b1}, q, a2);
    xfer(8'hFF, d, n);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // Pointer write, then two bytes read; the master acknowledges the first
  task automatic readTwo(input logic [6:0] dev, input logic [7:0] ptr,
    output logic [7:0] d0, output logic [7:0] d1, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, n;
    start();
    xfer({dev, 1'b0}, q, a0);
    xfer(ptr, q, a1);
    start();
    xfer({dev, 1'b1}, q, a2);
    for (int i = 7; i >= 0; i--) bitx(1'b1, d0[i]);
    bitx(1'b0, n);
    xfer(8'hFF, d1, n);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the threshold configuration bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // Design inputs, all valued at time zero
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic otpBlank = 1'b1;
  logic addressSelectPin = 1'b0;
  // Bus wires; data has a pull-up
  wire sclIn;
  wire sdaPull;
  wire sdaOut;
  wire sdaOe;
  wire sdaIn = !(sdaPull || (sdaOe && !sdaOut));
  // Levels gathered as one vector
  wire [21:0] levels;
  wire fuseLocked;
  wire fuseBurnBusy;
  int num_errors = 0;
  int comparisons = 0;
  // Rows: pointer, written byte, expected readback
  logic [23:0] rows [7] = '{24'h01_FA0A, 24'h02_F505, 24'h03_3C0C, 24'h04_A303,
    24'h05_FE06, 24'h06_F901, 24'h20_5500};
  always #12.5 core_clk = ~core_clk;
  // Short burn keeps the run brief
  itcb_config_bank #(.BURN_CYCLES(20)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .otpBlank(otpBlank),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addressSelectPin(addressSelectPin),
    .overvoltageLevel(levels[21:18]), .undervoltageLevel(levels[17:14]),
    .turnOnLevel(levels[13:10]), .turnOffLevel(levels[9:6]),
    .logicRailResetLevel(levels[5:3]), .coreRailResetLevel(levels[2:0]),
    .fuseLocked(fuseLocked), .fuseBurnBusy(fuseBurnBusy));
  itcb_host_model host (.core_clk(core_clk), .sdaIn(sdaIn), .sclOut(sclIn), .sdaPull(sdaPull));
  // Compare values
  task automatic checkVal(input string what, input logic [21:0] exp, input logic [21:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Compare single flags
  task automatic checkAck(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  // Power cycle: fuses survive, overrides do not
  task automatic pulseReset();
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // Bounded wait for the burn to finish
  task automatic waitIdle();
    for (int i = 0; i < 100 && fuseBurnBusy !== 1'b0; i++) @(posedge core_clk);
  endtask
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] d2;
    logic ok;
    @(posedge core_clk);
    otpBlank <= 1'b0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    checkVal("levels", 22'h00_0000, levels);
    $display("Test reset done");
    for (int i = 0; i < 7; i++) begin
      host.writeReg(7'h2E, rows[i][23:16], rows[i][15:8], ok);
      checkAck("write ack", 1'b1, ok);
      host.readReg(7'h2E, rows[i][23:16], d, ok);
      checkAck("read ack", 1'b1, ok);
      checkVal("readback", {14'h0, rows[i][7:0]}, {14'h0, d});
    end
    checkVal("levels", {4'hA, 4'h5, 4'hC, 4'h3, 3'h6, 3'h1}, levels);
    checkVal("reset levels", 22'h00_0031, {16'h0, levels[5:0]});
    // Master acknowledge hands out the same register once more
    host.readTwo(7'h2E, 8'h03, d, d2, ok);
    checkAck("repeat ack", 1'b1, ok);
    checkVal("repeat first", 22'h00_000C, {14'h0, d});
    checkVal("repeat second", 22'h00_000C, {14'h0, d2});
    $display("Test table done");
    // Only the strapped address answers
    for (int p = 0; p < 2; p++) begin
      addressSelectPin <= p[0];
      repeat (4) @(posedge core_clk);
      host.writeReg(7'h2E, 8'h01, 8'h07, ok);
      checkAck("ack 2E", !p[0], ok);
      host.writeReg(7'h2F, 8'h01, 8'h08, ok);
      checkAck("ack 2F", p[0], ok);
      checkVal("strap level", {18'h0, p[0] ? 4'h8 : 4'h7}, {18'h0, levels[21:18]});
    end
    $display("Test strap done");
    host.writeReg(7'h2F, 8'h10, 8'h01, ok);
    waitIdle();
    host.writeReg(7'h2F, 8'h01, 8'h02, ok);
    checkVal("override", 22'h00_0002, {18'h0, levels[21:18]});
    pulseReset();
    checkVal("fuse defaults", {4'h8, 4'h5, 4'hC, 4'h3, 3'h6, 3'h1}, levels);
    $display("Test burn done");
    host.writeReg(7'h2F, 8'h15, 8'h01, ok);
    host.readReg(7'h2F, 8'h15, d, ok);
    checkVal("staged lock", 22'h00_0001, {14'h0, d});
    host.writeReg(7'h2F, 8'h10, 8'h01, ok);
    waitIdle();
    checkAck("lock fuse", 1'b1, fuseLocked);
    // A burn after locking must leave the fuses alone
    host.writeReg(7'h2F, 8'h03, 8'h0F, ok);
    host.writeReg(7'h2F, 8'h10, 8'h01, ok);
    waitIdle();
    host.readReg(7'h2F, 8'h10, d, ok);
    checkVal("burn status", 22'h00_0002, {14'h0, d});
    pulseReset();
    checkVal("turn-on level", 22'h00_000C, {18'h0, levels[13:10]});
    $display("Test lock done");
    end_sim();
  end
  // Watchdog at about twice the expected run
  initial begin
    #400000;
    num_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    end_sim();
  end
endmodule
bind itcb_config_bank itcb_checker #(.BURN_CYCLES(BURN_CYCLES)) chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .otpBlank(otpBlank), .sclIn(sclIn),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .addressSelectPin(addressSelectPin),
  .overvoltageLevel(overvoltageLevel), .undervoltageLevel(undervoltageLevel),
  .turnOnLevel(turnOnLevel), .turnOffLevel(turnOffLevel),
  .logicRailResetLevel(logicRailResetLevel), .coreRailResetLevel(coreRailResetLevel),
  .fuseLocked(fuseLocked), .fuseBurnBusy(fuseBurnBusy));
`default_nettype wire
